/* rtl/dmacpa_pkg.sv */
// Package of constants for the channel progress and abort block
package dmacpa_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_SRC_ADDR   = 8'h00;
  localparam logic [7:0] OFF_DEST_ADDR  = 8'h04;
  localparam logic [7:0] OFF_REMAINING  = 8'h08;
  localparam logic [7:0] OFF_CTRL       = 8'h0C;
  localparam logic [7:0] OFF_ABORT      = 8'h10;
  localparam logic [7:0] OFF_STATUS     = 8'h14;
  // Control field positions
  localparam int CTRL_EN        = 0;
  localparam int CTRL_SRC_STEP  = 1;
  localparam int CTRL_DEST_STEP = 2;
  localparam int CTRL_QUIET     = 3;
  localparam int CTRL_SIZE_LO   = 4;
  localparam int CTRL_RING_LO   = 8;
  localparam int CTRL_RING_DEST = 12;
  localparam int CTRL_IRQ_EN    = 13;
  localparam int CTRL_TRIGGER   = 14;
  // Status field positions
  localparam int ST_BUSY  = 0;
  localparam int ST_INT   = 1;
  localparam int ST_ABORT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0006;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  // Channel states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_DRAIN = 3'b100
  } dmacpa_state_type;
endpackage

/* rtl/dmacpa_pipe_if.sv */
// Interface between the channel core and its in-flight tracker
`timescale 1ns/1ps
interface dmacpa_pipe_if;
  logic       issue;
  logic       done;
  logic       flush;
  logic [3:0] inflight;
  logic       full;
  modport core (output issue, output done, output flush, input inflight, input full);
  modport trk  (input issue, input done, input flush, output inflight, output full);
endinterface

/* rtl/dmacpa_inflight.sv */
// In-flight transfer counter
`timescale 1ns/1ps
module dmacpa_inflight #(
  parameter int DEPTH = 4
) (
  input  wire logic    clock_i,
  input  wire logic    rst_n_i,
  dmacpa_pipe_if.trk   pipe
);
  // Refuse depths the four-bit counter cannot hold
  if (DEPTH < 1 || DEPTH > 15) begin : g_depth_bad
    $error("DEPTH out of range");
  end
  logic [3:0] cnt_r;
  // Count issues minus completions
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
    end else begin
      case ({pipe.issue, pipe.done && cnt_r != 4'h0})
        2'b10:   cnt_r <= cnt_r + 4'h1;
        2'b01:   cnt_r <= cnt_r - 4'h1;
        default: cnt_r <= cnt_r;
      endcase
    end
  end
  assign pipe.inflight = cnt_r;
  assign pipe.full     = (cnt_r == 4'(DEPTH)) || pipe.flush; // Closed while an abort drains
endmodule

/* rtl/dmacpa_channel.sv */
// DMA channel with progress read-back and abort
//
// Behaviour
// - Address counters advance when an address enters the bus pipeline.
// - Address read-back subtracts in-flight count times transfer size while running.
// - Adjustment follows actual stepping: none if not stepping, wraps within ring.
// - Remaining-count read-back adds back in-flight transfers.
// - Abort cancels the sequence, including one stalled on a data request.
// - In-flight means issued, write not yet done.
// - Completion after draining sets interrupt flag unless quiet is set or the sequence was aborted.
// - Busy stays high until all in-flight transfers of an abort finish.
`timescale 1ns/1ps
module dmacpa_channel #(
  parameter int DEPTH = 4
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        peripheral_data_request_i,
  output logic [31:0]      bus_read_addr_o,
  output logic [31:0]      bus_write_addr_o,
  output logic             bus_issue_o,
  input  wire logic        bus_read_done_i,
  input  wire logic        bus_write_done_i,
  output logic             irq_o
);
  dmacpa_pipe_if pipe ();
  dmacpa_inflight #(.DEPTH(DEPTH)) dmacpa_inflight_i (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .pipe    (pipe)
  );

  dmacpa_pkg::dmacpa_state_type state_r;
  logic [31:0] src_r;
  logic [31:0] dest_r;
  logic [31:0] remaining_r;
  logic [31:0] ctrl_r;
  logic        int_r;
  logic        abort_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        reads_pending_r;
  logic        wr_fire;
  logic        go;
  logic        src_on;
  logic        dest_on;
  logic [31:0] step;
  logic [31:0] lag;
  logic [31:0] ring_mask;
  logic [31:0] wmask;
  logic [31:0] wval;

  // Write strobe mask and merged value
  always_comb begin
    wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wval  = wdata_r & wmask;
  end

  // Transfer size, stepping, ring mask
  always_comb begin
    step      = 32'h0000_0001 << ctrl_r[dmacpa_pkg::CTRL_SIZE_LO +: 2];
    src_on    = ctrl_r[dmacpa_pkg::CTRL_SRC_STEP];
    dest_on   = ctrl_r[dmacpa_pkg::CTRL_DEST_STEP];
    ring_mask = (ctrl_r[dmacpa_pkg::CTRL_RING_LO +: 4] == 4'h0) ? 32'hFFFF_FFFF
              : ((32'h0000_0001 << ctrl_r[dmacpa_pkg::CTRL_RING_LO +: 4]) - 32'h0000_0001);
    lag       = 32'(pipe.inflight) * step;
  end

  // Issue when running, request present and pipeline has room
  assign go = (state_r == dmacpa_pkg::ST_RUN) && !abort_r && peripheral_data_request_i
              && !pipe.full && remaining_r != 32'h0000_0000;
  assign pipe.issue = go;
  assign pipe.done  = bus_write_done_i;
  assign pipe.flush = abort_r;

  // AXI write address and data capture, in either order
  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dmacpa_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r > dmacpa_pkg::OFF_STATUS || awaddr_r[1:0] != 2'b00)
                      ? dmacpa_pkg::RESP_SLVERR : dmacpa_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl_r <= dmacpa_pkg::CTRL_RESET;
    end else if (wr_fire && awaddr_r == dmacpa_pkg::OFF_CTRL) begin
      ctrl_r <= ((ctrl_r & ~wmask) | wval) & ~(32'h0000_0001 << dmacpa_pkg::CTRL_TRIGGER);
    end
  end

  // Channel state and abort handling
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_r <= dmacpa_pkg::ST_IDLE;
      abort_r <= 1'b0;
    end else begin
      case (state_r)
        dmacpa_pkg::ST_IDLE: begin
          abort_r <= 1'b0;
          if (wr_fire && awaddr_r == dmacpa_pkg::OFF_CTRL && wstrb_r[1]
              && wdata_r[dmacpa_pkg::CTRL_TRIGGER] && wdata_r[dmacpa_pkg::CTRL_EN]) begin
            state_r <= dmacpa_pkg::ST_RUN;
          end
        end
        dmacpa_pkg::ST_RUN: begin
          if (wr_fire && awaddr_r == dmacpa_pkg::OFF_ABORT && wstrb_r[0] && wdata_r[0]) begin
            abort_r <= 1'b1;
            state_r <= dmacpa_pkg::ST_DRAIN;
          end else if (remaining_r == 32'h0000_0000 || (go && remaining_r == 32'h0000_0001)) begin
            state_r <= dmacpa_pkg::ST_DRAIN;
          end
        end
        dmacpa_pkg::ST_DRAIN: begin
          // Busy holds until the pipeline is empty
          if (pipe.inflight == 4'h0 && !reads_pending_r) begin
            state_r <= dmacpa_pkg::ST_IDLE;
            abort_r <= 1'b0;
          end
        end
        default: state_r <= dmacpa_pkg::ST_IDLE;
      endcase
    end
  end

  // Tracks issued transfers whose read has not finished
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      reads_pending_r <= 1'b0;
    end else if (go) begin
      reads_pending_r <= 1'b1;
    end else if (bus_read_done_i) begin
      reads_pending_r <= 1'b0;
    end
  end

  // Address counters advance at issue; the one picked by the ring-dest bit wraps inside the ring
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      src_r  <= 32'h0000_0000;
      dest_r <= 32'h0000_0000;
    end else if (go) begin
      if (src_on) begin
        src_r <= ctrl_r[dmacpa_pkg::CTRL_RING_DEST] ? src_r + step
               : (src_r & ~ring_mask) | ((src_r + step) & ring_mask);
      end
      if (dest_on) begin
        dest_r <= !ctrl_r[dmacpa_pkg::CTRL_RING_DEST] ? dest_r + step
                : (dest_r & ~ring_mask) | ((dest_r + step) & ring_mask);
      end
    end else if (wr_fire && state_r == dmacpa_pkg::ST_IDLE) begin
      if (awaddr_r == dmacpa_pkg::OFF_SRC_ADDR) src_r <= (src_r & ~wmask) | wval;
      if (awaddr_r == dmacpa_pkg::OFF_DEST_ADDR) dest_r <= (dest_r & ~wmask) | wval;
    end
  end

  // Remaining count decrements at issue
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      remaining_r <= 32'h0000_0000;
    end else if (go) begin
      remaining_r <= remaining_r - 32'h0000_0001;
    end else if (wr_fire && state_r == dmacpa_pkg::ST_IDLE
                 && awaddr_r == dmacpa_pkg::OFF_REMAINING) begin
      remaining_r <= (remaining_r & ~wmask) | wval;
    end
  end

  // Interrupt flag: hardware set wins over software clear
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      int_r <= 1'b0;
    end else if (state_r == dmacpa_pkg::ST_DRAIN && pipe.inflight == 4'h0 && !reads_pending_r
                 && !abort_r && !ctrl_r[dmacpa_pkg::CTRL_QUIET]) begin
      int_r <= 1'b1;
    end else if (wr_fire && awaddr_r == dmacpa_pkg::OFF_STATUS && wstrb_r[0]
                 && wdata_r[dmacpa_pkg::ST_INT]) begin
      int_r <= 1'b0;
    end
  end

  // Interrupt output gated by enable
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= int_r && ctrl_r[dmacpa_pkg::CTRL_IRQ_EN];
    end
  end

  // Pipeline-side outputs
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bus_issue_o      <= 1'b0;
      bus_read_addr_o  <= 32'h0000_0000;
      bus_write_addr_o <= 32'h0000_0000;
    end else begin
      bus_issue_o      <= go;
      bus_read_addr_o  <= src_r;
      bus_write_addr_o <= dest_r;
    end
  end

  // Read channel with in-flight correction
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= dmacpa_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= dmacpa_pkg::RESP_OKAY;
        case (s_axi_araddr)
          dmacpa_pkg::OFF_SRC_ADDR:
            s_axi_rdata <= !src_on ? src_r
              : ctrl_r[dmacpa_pkg::CTRL_RING_DEST] ? src_r - lag
              : (src_r & ~ring_mask) | ((src_r - lag) & ring_mask);
          dmacpa_pkg::OFF_DEST_ADDR:
            s_axi_rdata <= !dest_on ? dest_r
              : !ctrl_r[dmacpa_pkg::CTRL_RING_DEST] ? dest_r - lag
              : (dest_r & ~ring_mask) | ((dest_r - lag) & ring_mask);
          dmacpa_pkg::OFF_REMAINING: s_axi_rdata <= remaining_r + 32'(pipe.inflight);
          dmacpa_pkg::OFF_CTRL:      s_axi_rdata <= ctrl_r;
          dmacpa_pkg::OFF_ABORT:     s_axi_rdata <= {31'h0, abort_r};
          dmacpa_pkg::OFF_STATUS:
            s_axi_rdata <= {29'h0, abort_r, int_r, state_r != dmacpa_pkg::ST_IDLE};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= dmacpa_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* dv/dmacpa_channel_monitor.sv */
// Port checker for the channel block
`timescale 1ns/1ps
module dmacpa_channel_monitor #(
  parameter int DEPTH = 4
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic s_axi_awvalid,
  input  wire logic s_axi_awready,
  input  wire logic s_axi_bvalid,
  input  wire logic s_axi_bready,
  input  wire logic s_axi_arvalid,
  input  wire logic s_axi_arready,
  input  wire logic s_axi_rvalid,
  input  wire logic s_axi_rready,
  input  wire logic peripheral_data_request_i,
  input  wire logic bus_issue_o,
  input  wire logic bus_write_done_i,
  input  wire logic irq_o
);
  int inflight_r;
  int since_wd_r;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Issued minus written, and cycles since last write
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      inflight_r <= 0;
      since_wd_r <= 15;
    end else begin
      inflight_r <= inflight_r + int'(bus_issue_o) - int'(bus_write_done_i);
      since_wd_r <= bus_write_done_i ? 0 : (since_wd_r < 15 ? since_wd_r + 1 : 15);
    end
  end
  property p_issue_req; bus_issue_o |-> $past(peripheral_data_request_i); endproperty
  a_issue_req: assert property (p_issue_req) else $error("issue without request");
  property p_inflight_max; inflight_r <= DEPTH; endproperty
  a_inflight_max: assert property (p_inflight_max) else $error("in flight too high");
  property p_irq_cause; $rose(irq_o) |-> since_wd_r < 8; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without completion");
  property p_b_after_aw; s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid; endproperty
  a_b_after_aw: assert property (p_b_after_aw) else $error("no write response");
  property p_r_after_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_after_ar: assert property (p_r_after_ar) else $error("no read data");
  property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready too long");
  property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_once: assert property (p_r_once) else $error("rvalid repeated");
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("bvalid repeated");
  c_issue: cover property (bus_issue_o);
  c_irq: cover property ($rose(irq_o));
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind dmacpa_channel dmacpa_channel_monitor #(.DEPTH(DEPTH)) dmacpa_channel_monitor_i (
  .clock_i, .rst_n_i, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .peripheral_data_request_i, .bus_issue_o, .bus_write_done_i, .irq_o);

/* dv/dmacpa_bus_model.sv */
// Bus pipeline model for issued transfers
`timescale 1ns/1ps
module dmacpa_bus_model (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic hold_i,
  input  wire logic issue_i,
  output logic      read_done_o,
  output logic      write_done_o
);
  int   pend;
  logic wd;
  // Write may finish once its read has, one every other cycle
  assign wd = !hold_i && pend > 0 && !write_done_o;
  // Read ends next cycle, write waits while held
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      pend <= 0;
      read_done_o <= 1'b0;
      write_done_o <= 1'b0;
    end else begin
      read_done_o <= issue_i;
      write_done_o <= wd;
      pend <= pend + int'(read_done_o) - int'(wd);
    end
  end
endmodule

/* dv/dmacpa_channel_tb.sv */
// Testbench for the channel progress and abort block
`timescale 1ns/1ps
module dmacpa_channel_tb;
  localparam logic [7:0] SRC = dmacpa_pkg::OFF_SRC_ADDR;
  localparam logic [7:0] DST = dmacpa_pkg::OFF_DEST_ADDR;
  localparam logic [7:0] REM = dmacpa_pkg::OFF_REMAINING;
  localparam logic [7:0] CTL = dmacpa_pkg::OFF_CTRL;
  localparam logic [7:0] STS = dmacpa_pkg::OFF_STATUS;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp, wrsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        clock_i, rst_n_i, req, hold, issue, rdone, wdone, irq_o;
  logic [31:0] ra, wa, ra_last, wa_last;
  int          bad_count, samples_checked, n_iss, cyc, base;
  dmacpa_channel #(.DEPTH(4)) dmacpa_channel_i (.clock_i, .rst_n_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .peripheral_data_request_i(req),
    .bus_read_addr_o(ra), .bus_write_addr_o(wa), .bus_issue_o(issue), .bus_read_done_i(rdone),
    .bus_write_done_i(wdone), .irq_o);
  dmacpa_bus_model dmacpa_bus_model_i (.clock_i, .rst_n_i, .hold_i(hold), .issue_i(issue),
    .read_done_o(rdone), .write_done_o(wdone));
  // Clock
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Issue counter and hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (issue === 1'b1) begin
      n_iss++;
      ra_last = ra;
      wa_last = wa;
    end
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    wrsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rc(logic [7:0] a, logic [31:0] e, string n);
    rd(a);
    chk(n, rdat, e);
  endtask
  task automatic idle();
    do rd(STS); while (rdat[0] !== 1'b0);
  endtask
  task automatic start(logic [31:0] n, logic [31:0] c);
    base = n_iss;
    wr(SRC, 32'h0000_1000);
    wr(DST, 32'h0000_2000);
    wr(REM, n);
    wr(CTL, c);
  endtask
  task automatic t_reset();
    rc(CTL, dmacpa_pkg::CTRL_RESET, "ctrl reset");
    rc(STS, 32'h0000_0000, "status reset");
    rc(8'h18, 32'h0000_0000, "unmapped data");
    chk("unmapped rresp", 32'(rrsp), 32'(dmacpa_pkg::RESP_SLVERR));
    wr(8'h1C, 32'h0000_0001);
    chk("unmapped bresp", 32'(wrsp), 32'(dmacpa_pkg::RESP_SLVERR));
  endtask
  task automatic t_run(logic [31:0] c, logic [31:0] sf, logic [31:0] df, logic [31:0] sl,
                       logic [31:0] dl);
    hold <= 1'b1;
    req <= 1'b1;
    start(32'h0000_0004, c);
    while (n_iss < base + 4) @(posedge clock_i);
    chk("last read addr", ra_last, sl);
    chk("last write addr", wa_last, dl);
    rc(SRC, 32'h0000_1000, "src in flight");
    rc(DST, 32'h0000_2000, "dest in flight");
    rc(REM, 32'h0000_0004, "count in flight");
    rc(STS, 32'h0000_0001, "busy running");
    hold <= 1'b0;
    idle();
    rc(SRC, sf, "src final");
    rc(DST, df, "dest final");
    rc(STS, {30'h0, ~c[3], 1'b0}, "status done");
    chk("irq", {31'h0, irq_o}, {31'h0, ~c[3]});
    wr(STS, 32'h0000_0002);
  endtask
  task automatic t_abort();
    hold <= 1'b1;
    start(32'h0000_0008, 32'h0000_6027);
    while (n_iss < base + 4) @(posedge clock_i);
    wr(CTL, 32'h0000_0027);
    wr(8'h10, 32'h0000_0001);
    rc(STS, 32'h0000_0005, "abort draining");
    hold <= 1'b0;
    idle();
    rc(STS, 32'h0000_0000, "abort done");
    wr(STS, 32'h0000_0002);
    wr(CTL, 32'h0000_2026);
    chk("issues after abort", n_iss, base + 4);
    req <= 1'b0;
    start(32'h0000_0002, 32'h0000_6027);
    rc(STS, 32'h0000_0001, "stalled busy");
    wr(8'h10, 32'h0000_0001);
    idle();
    req <= 1'b1;
    repeat (10) @(posedge clock_i);
    chk("issues after stall abort", n_iss, base);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_n_i, req, hold, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_run(32'h0000_6027, 32'h0000_1010, 32'h0000_2010, 32'h0000_100C, 32'h0000_200C);
    t_run(32'h0000_6025, 32'h0000_1000, 32'h0000_2010, 32'h0000_1000, 32'h0000_200C);
    t_run(32'h0000_602F, 32'h0000_1010, 32'h0000_2010, 32'h0000_100C, 32'h0000_200C);
    t_run(32'h0000_6327, 32'h0000_1000, 32'h0000_2010, 32'h0000_1004, 32'h0000_200C);
    t_run(32'h0000_7327, 32'h0000_1010, 32'h0000_2000, 32'h0000_100C, 32'h0000_2004);
    t_run(32'h0000_6013, 32'h0000_1008, 32'h0000_2000, 32'h0000_1006, 32'h0000_2000);
    t_abort();
    conclude();
  end
endmodule
